// ---- dcm_pkg.sv ----
package dcm_pkg;

  // Protected field identifiers on the field access port
  localparam logic [1:0] FLD_GAIN = 2'h0;
  localparam logic [1:0] FLD_OFFSET = 2'h1;
  localparam logic [1:0] FLD_SAMPLE = 2'h2;
  localparam int NUM_FIELDS = 3;
  localparam int FIELD_BYTES = 3;

  // Gain field layout: coefficient in bytes 0..1, width code in byte 2 [3:0]
  localparam int GAIN_COEF_W = 16;
  localparam int GAIN_WIDTH_LSB = 16;
  localparam int GAIN_WIDTH_W = 4;
  localparam logic [23:0] GAIN_FIELD_MASK = 24'h0fffff;

  // Reset values of the fields, their shadows, the interlock flags and the read data
  localparam logic [23:0] FIELD_RST = 24'h000000;
  localparam logic [2:0] CIF_RST = 3'h7;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // Operating modes, two-bit select
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_FAST = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] MODE_FIR = 2'h3;

  // Decimation periods blocked after a channel reset
  localparam int SETTLE_PERIODS = 3;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHRST = 2'b01,
    ST_SETTLE = 2'b10,
    ST_RUN = 2'b11
  } dcm_state_e;

endpackage

// ---- dcm_decimator_ctrl.sv ----
`timescale 1ns/100ps
// Function
// RQ1 - Coherency tracking acts only when enabled; otherwise fields are plain registers
// RQ2 - Three tracked fields: gain with width, offset (write side), output sample (read side)
// RQ3 - Software picks the key byte; accessing it completes a field update
// RQ4 - Each of the three fields keeps its own interlock flag
// RQ5 - Byte and halfword accesses both mark the bytes they touch
// RQ6 - Hard or soft reset sets all three interlock flags coherent
// RQ7 - Writing a non-key gain or offset byte while coherent clears its flag
// RQ8 - While a write field is incoherent the datapath uses its shadow copy
// RQ9 - Key byte write sets flag; next need loads new value into shadow
// RQ10 - Reading a non-key output sample byte while coherent clears its flag
// RQ11 - Incoherent output sample is frozen; new results are dropped silently; the code pulses sampleDropped for each dropped result
// RQ12 - Reading the sample key byte sets its flag; next result is stored
// RQ13 - A two-bit control field picks one of four operating modes
// RQ14 - Single sample: start, convert four periods, capture, flag done, back to standby
// RQ15 - Fast filter: repeated single samples with channel reset between each
// RQ16 - Continuous: reset once, block three periods, then one result per period
// RQ17 - Fast FIR: reset, block three, accumulate fir ratio plus one, emit, repeat
// RQ18 - Modes start by software start bit write or external start input
// RQ19 - External start select set means the software start bit is ignored
// RQ20 - Offset field is a 24-bit signed two's complement value
// RQ21 - Halfword touching the key byte counts as key access, leaving flag coherent
module dcm_decimator_ctrl
  import dcm_pkg::*;
#(
  parameter int RATIO_W = 8,
  parameter int FIR_W = 10
)
(
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic softRst,
  // Coherency control
  input wire logic [2:0] cohEnable,
  input wire logic [1:0] keyGain,
  input wire logic [1:0] keyOffset,
  input wire logic [1:0] keySample,
  // Decimator control
  input wire logic [1:0] modeSel,
  input wire logic softStartWrite,
  input wire logic extStartSel,
  input wire logic extStart,
  input wire logic stopCmd,
  input wire logic [RATIO_W-1:0] cicRatio,
  input wire logic [FIR_W-1:0] firRatio,
  // Field access port
  input wire logic fldAccess,
  input wire logic fldWrite,
  input wire logic [1:0] fldSel,
  input wire logic [1:0] fldByte,
  input wire logic fldHalf,
  input wire logic [15:0] fldWdata,
  output logic [15:0] fldRdata,
  // Post-processor result
  input wire logic resultValid,
  input wire logic [23:0] resultData,
  // Coefficients to the datapath and the held output sample
  output logic [GAIN_COEF_W-1:0] gainCoef,
  output logic [GAIN_WIDTH_W-1:0] gainWidth,
  output logic signed [23:0] offsetCoef,
  output logic [23:0] outSample,
  // Status
  output logic [2:0] interlockFlag,
  output logic sampleDropped,
  output logic busy,
  // Sequencer strobes
  output logic chanReset,
  output logic periodTick,
  output logic firSample,
  output logic resultCapture,
  output logic convDone
);

  // Bytes of a field touched by one access; a halfword also takes the next byte
  function automatic logic [2:0] touchMask(input logic [1:0] b, input logic half);
    logic [2:0] m;
    m = 3'h0;
    case (b)
      2'h0: m = half ? 3'h3 : 3'h1;
      2'h1: m = half ? 3'h6 : 3'h2;
      2'h2: m = 3'h4;
      default: m = 3'h0;
    endcase
    return m;
  endfunction

  // Merge written bytes into a field; low data byte lands on the addressed byte
  function automatic logic [23:0] mergeBytes(input logic [23:0] old, input logic [2:0] m,
                                             input logic [1:0] b, input logic [15:0] wd);
    logic [23:0] v;
    v = old;
    for (int i = 0; i < FIELD_BYTES; i++)
    begin
      if (m[i])
      begin
        v[i*8 +: 8] = (i == int'(b)) ? wd[7:0] : wd[15:8];
      end
    end
    return v;
  endfunction

  logic clr;
  logic [2:0] accMask;
  logic [1:0] keyArr [NUM_FIELDS];
  logic [2:0] cif_r, cif_nxt;
  logic [23:0] gainFld_r, gainFld_nxt;
  logic [23:0] offsetFld_r, offsetFld_nxt;
  logic [23:0] sampleFld_r, sampleFld_nxt;
  logic [23:0] gainShd_r, gainShd_nxt;
  logic [23:0] offsetShd_r, offsetShd_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic dropped_r, dropped_nxt;
  logic needLoad;

  assign clr = rst | softRst;
  assign accMask = touchMask(fldByte, fldHalf); // see RQ5
  assign keyArr[0] = keyGain;
  assign keyArr[1] = keyOffset;
  assign keyArr[2] = keySample;

  // Interlock flags, one per field; a disabled field always reads coherent
  always_comb
  begin
    logic hit;
    hit = 1'b0;
    cif_nxt = cif_r;
    for (int f = 0; f < NUM_FIELDS; f++)
    begin
      // Gain and offset track writes, the output sample tracks reads
      hit = fldAccess && (fldSel == 2'(f)) && (fldWrite == (f != 2)); // see RQ2
      if (!cohEnable[f])
      begin
        cif_nxt[f] = 1'b1; // see RQ1
      end
      else if (hit && accMask[keyArr[f]])
      begin
        cif_nxt[f] = 1'b1; // see RQ3, RQ9, RQ12, RQ21
      end
      else if (hit && (accMask != 3'h0))
      begin
        cif_nxt[f] = 1'b0; // see RQ7, RQ10
      end
    end
  end

  // Field storage; gain and offset writes always land, only their datapath view is guarded; results are guarded at the sample field
  always_comb
  begin
    gainFld_nxt = gainFld_r;
    offsetFld_nxt = offsetFld_r;
    sampleFld_nxt = sampleFld_r;
    dropped_nxt = 1'b0;
    if (fldAccess && fldWrite && (fldSel == FLD_GAIN))
    begin
      gainFld_nxt = mergeBytes(gainFld_r, accMask, fldByte, fldWdata) & GAIN_FIELD_MASK;
    end
    if (fldAccess && fldWrite && (fldSel == FLD_OFFSET))
    begin
      offsetFld_nxt = mergeBytes(offsetFld_r, accMask, fldByte, fldWdata);
    end
    // Sample is written by hardware only; software writes are ignored
    if (resultValid)
    begin
      if (!cohEnable[2] || cif_r[2])
      begin
        sampleFld_nxt = resultData; // see RQ12
      end
      else
      begin
        dropped_nxt = 1'b1; // see RQ11
      end
    end
  end

  // Shadows follow the fields at a point of need when coherent, and every cycle when tracking is off
  always_comb
  begin
    gainShd_nxt = gainShd_r;
    offsetShd_nxt = offsetShd_r;
    // Disabled tracking passes the field through every cycle
    if (!cohEnable[0] || (cif_r[0] && needLoad))
    begin
      gainShd_nxt = gainFld_r; // see RQ8, RQ9
    end
    if (!cohEnable[1] || (cif_r[1] && needLoad))
    begin
      offsetShd_nxt = offsetFld_r; // see RQ8, RQ9
    end
  end

  // Read data, registered one cycle after the access
  always_comb
  begin
    logic [23:0] src;
    src = sampleFld_r;
    rdata_nxt = rdata_r;
    case (fldSel)
      FLD_GAIN: src = gainFld_r;
      FLD_OFFSET: src = offsetFld_r;
      FLD_SAMPLE: src = sampleFld_r;
      default: src = 24'h000000;
    endcase
    if (fldAccess && !fldWrite)
    begin
      rdata_nxt = 16'h0000;
      if (accMask[fldByte])
      begin
        rdata_nxt[7:0] = src[fldByte*8 +: 8];
      end
      if (fldHalf && (fldByte != 2'h2))
      begin
        rdata_nxt[15:8] = src[(fldByte+2'h1)*8 +: 8];
      end
    end
  end

  // Register the coherency state
  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      cif_r <= CIF_RST; // see RQ6
      gainFld_r <= FIELD_RST;
      offsetFld_r <= FIELD_RST;
      sampleFld_r <= FIELD_RST;
      gainShd_r <= FIELD_RST;
      offsetShd_r <= FIELD_RST;
      rdata_r <= RDATA_RST;
      dropped_r <= 1'b0;
    end
    else
    begin
      cif_r <= cif_nxt;
      gainFld_r <= gainFld_nxt;
      offsetFld_r <= offsetFld_nxt;
      sampleFld_r <= sampleFld_nxt;
      gainShd_r <= gainShd_nxt;
      offsetShd_r <= offsetShd_nxt;
      rdata_r <= rdata_nxt;
      dropped_r <= dropped_nxt;
    end
  end

  assign fldRdata = rdata_r;
  assign interlockFlag = cif_r; // see RQ4
  assign sampleDropped = dropped_r;
  assign outSample = sampleFld_r;
  assign gainCoef = gainShd_r[GAIN_COEF_W-1:0];
  assign gainWidth = gainShd_r[GAIN_WIDTH_LSB +: GAIN_WIDTH_W];
  assign offsetCoef = signed'(offsetShd_r); // see RQ20

  // External start synchroniser; the first stage feeds only the second
  logic extSync1_r, extSync2_r, extPrev_r;
  logic startEvt;

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      extSync1_r <= 1'b0;
      extSync2_r <= 1'b0;
      extPrev_r <= 1'b0;
    end
    else
    begin
      extSync1_r <= extStart;
      extSync2_r <= extSync1_r;
      extPrev_r <= extSync2_r;
    end
  end

  // Select the start source; the soft bit is dead while external is chosen
  assign startEvt = extStartSel ? (extSync2_r & ~extPrev_r) : softStartWrite; // see RQ18, RQ19

  // Sequencer state
  dcm_state_e state_r, state_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic [RATIO_W-1:0] cycCnt_r, cycCnt_nxt;
  logic [FIR_W:0] prdCnt_r, prdCnt_nxt;
  logic tick_r, tick_nxt;
  logic fir_r, fir_nxt;
  logic cap_r, cap_nxt;
  logic done_r, done_nxt;
  logic periodEnd;
  logic [RATIO_W-1:0] lastCyc;

  // A ratio of zero is taken as one so the period still ends
  assign lastCyc = (cicRatio == '0) ? '0 : cicRatio - RATIO_W'(1);
  assign periodEnd = ((state_r == ST_SETTLE) || (state_r == ST_RUN)) && (cycCnt_r == lastCyc);
  // Coefficients are needed at each period boundary and at channel reset
  assign needLoad = periodEnd || (state_r == ST_CHRST);

  // Mode sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    cycCnt_nxt = cycCnt_r;
    prdCnt_nxt = prdCnt_r;
    tick_nxt = 1'b0;
    fir_nxt = 1'b0;
    cap_nxt = 1'b0;
    done_nxt = 1'b0;
    if ((state_r == ST_SETTLE) || (state_r == ST_RUN))
    begin
      cycCnt_nxt = periodEnd ? '0 : cycCnt_r + RATIO_W'(1);
      tick_nxt = periodEnd;
    end
    case (state_r)
      ST_IDLE:
      begin
        if (startEvt)
        begin
          mode_nxt = modeSel; // see RQ13
          state_nxt = ST_CHRST;
        end
      end
      ST_CHRST:
      begin
        // Every mode opens with a channel and modulator reset
        cycCnt_nxt = '0;
        prdCnt_nxt = '0;
        state_nxt = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        // Blocked periods give no result while the filter fills
        if (periodEnd)
        begin
          if (prdCnt_r == (FIR_W+1)'(SETTLE_PERIODS - 1))
          begin
            prdCnt_nxt = '0;
            state_nxt = ST_RUN; // see RQ16, RQ17
          end
          else
          begin
            prdCnt_nxt = prdCnt_r + (FIR_W+1)'(1);
          end
        end
      end
      ST_RUN:
      begin
        if (periodEnd)
        begin
          case (mode_r)
            MODE_SINGLE:
            begin
              cap_nxt = 1'b1;
              done_nxt = 1'b1;
              state_nxt = ST_IDLE; // see RQ14
            end
            MODE_FAST:
            begin
              cap_nxt = 1'b1;
              done_nxt = 1'b1;
              state_nxt = ST_CHRST; // see RQ15
            end
            MODE_CONT:
            begin
              cap_nxt = 1'b1;
              done_nxt = 1'b1; // see RQ16
            end
            default:
            begin
              // FIR mode sums fir ratio plus one periods per result
              fir_nxt = 1'b1;
              if (prdCnt_r == {1'b0, firRatio})
              begin
                cap_nxt = 1'b1;
                done_nxt = 1'b1;
                state_nxt = ST_CHRST; // see RQ17
              end
              else
              begin
                prdCnt_nxt = prdCnt_r + (FIR_W+1)'(1);
              end
            end
          endcase
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Stop wins over every state change and the capture and done strobes; a result in flight is abandoned
    if (stopCmd)
    begin
      state_nxt = ST_IDLE;
      cap_nxt = 1'b0;
      done_nxt = 1'b0;
    end
  end

  // Register the sequencer
  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      state_r <= ST_IDLE;
      mode_r <= MODE_SINGLE;
      cycCnt_r <= '0;
      prdCnt_r <= '0;
      tick_r <= 1'b0;
      fir_r <= 1'b0;
      cap_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      cycCnt_r <= cycCnt_nxt;
      prdCnt_r <= prdCnt_nxt;
      tick_r <= tick_nxt;
      fir_r <= fir_nxt;
      cap_r <= cap_nxt;
      done_r <= done_nxt;
    end
  end

  // Strobes to the datapath and status
  assign chanReset = (state_r == ST_CHRST);
  assign busy = (state_r != ST_IDLE);
  assign periodTick = tick_r;
  assign firSample = fir_r;
  assign resultCapture = cap_r;
  assign convDone = done_r;

endmodule

// ---- dcm_decimator_ctrl_asserts.sv ----
`timescale 1ns/100ps
// Port-level checks of coherency flags, sample capture and start control
module dcm_decimator_ctrl_asserts
  import dcm_pkg::*;
#(
  parameter int RATIO_W = 8
)
(
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic softRst,
  // Control
  input wire logic [2:0] cohEnable,
  input wire logic [1:0] keyOffset,
  input wire logic [1:0] keySample,
  input wire logic [1:0] modeSel,
  input wire logic softStartWrite,
  input wire logic extStartSel,
  input wire logic stopCmd,
  input wire logic [RATIO_W-1:0] cicRatio,
  // Field access and results
  input wire logic fldAccess,
  input wire logic fldWrite,
  input wire logic [1:0] fldSel,
  input wire logic [1:0] fldByte,
  input wire logic fldHalf,
  input wire logic resultValid,
  input wire logic [23:0] resultData,
  // Watched outputs
  input wire logic [23:0] outSample,
  input wire logic [2:0] interlockFlag,
  input wire logic sampleDropped,
  input wire logic busy,
  input wire logic chanReset,
  input wire logic convDone
);
  logic offW;
  logic smpR;
  // Byte-wide only; halfwords are judged by the bench
  assign offW = fldAccess && fldWrite && fldSel == FLD_OFFSET && !fldHalf;
  assign smpR = fldAccess && !fldWrite && fldSel == FLD_SAMPLE && !fldHalf;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst || softRst);

  // Reset check must not be disabled by the reset it watches
  reset_flags_a: assert property (
    disable iff (1'b0) (rst || softRst) |=> interlockFlag == 3'h7)
    else $error("flags not coherent after reset");
  offset_clear_a: assert property (
    offW && fldByte != keyOffset && cohEnable[1] && interlockFlag[1] |=> !interlockFlag[1])
    else $error("offset flag kept after non-key write");
  offset_key_a: assert property (offW && fldByte == keyOffset |=> interlockFlag[1])
    else $error("offset flag not set by key write");
  sample_clear_a: assert property (
    smpR && fldByte != keySample && cohEnable[2] && interlockFlag[2] |=> !interlockFlag[2])
    else $error("sample flag kept after non-key read");
  sample_key_a: assert property (smpR && fldByte == keySample |=> interlockFlag[2])
    else $error("sample flag not set by key read");
  sample_drop_a: assert property (
    resultValid && cohEnable[2] && !interlockFlag[2] |=> sampleDropped && $stable(outSample))
    else $error("incoherent sample changed");
  sample_store_a: assert property (
    resultValid && (interlockFlag[2] || !cohEnable[2])
    |=> outSample == $past(resultData) && !sampleDropped)
    else $error("coherent sample not stored");
  plain_field_a: assert property (!cohEnable[1] [*2] |-> interlockFlag[1])
    else $error("flag moved with tracking off");
  ext_only_a: assert property (
    !busy && softStartWrite && extStartSel |=> !busy ##1 !busy)
    else $error("soft start taken in external mode");
  soft_start_a: assert property (
    !busy && softStartWrite && !extStartSel && !stopCmd |=> chanReset && busy)
    else $error("soft start not taken");
  single_time_a: assert property (
    chanReset && modeSel == MODE_SINGLE && cicRatio == RATIO_W'(2) && !stopCmd
    |=> !convDone [*8] ##1 (convDone && !busy))
    else $error("single conversion length wrong");
endmodule

bind dcm_decimator_ctrl dcm_decimator_ctrl_asserts #(.RATIO_W(RATIO_W)) u_chk (
  .ref_clk, .rst, .softRst, .cohEnable, .keyOffset, .keySample, .modeSel,
  .softStartWrite, .extStartSel, .stopCmd, .cicRatio, .fldAccess, .fldWrite,
  .fldSel, .fldByte, .fldHalf, .resultValid, .resultData, .outSample,
  .interlockFlag, .sampleDropped, .busy, .chanReset, .convDone
);

// ---- dcm_bus_master.sv ----
`timescale 1ns/100ps
// Software side of the field port; caller orders the key byte last
module dcm_bus_master (
  // Clock
  input wire logic ref_clk,
  // Field access port
  output logic fldAccess,
  output logic fldWrite,
  output logic [1:0] fldSel,
  output logic [1:0] fldByte,
  output logic fldHalf,
  output logic [15:0] fldWdata
);
  // Idle port until the first request
  initial
  begin
    fldAccess = 1'b0;
    fldWrite = 1'b0;
    fldSel = 2'h0;
    fldByte = 2'h0;
    fldHalf = 1'b0;
    fldWdata = 16'h0000;
  end

  // One access per call; inverted data when idle so stale values never match
  task automatic acc(input logic w, input logic [1:0] s, input logic [1:0] b,
                     input logic h, input logic [15:0] d);
    @(negedge ref_clk);
    fldAccess = 1'b1;
    fldWrite = w;
    fldSel = s;
    fldByte = b;
    fldHalf = h;
    fldWdata = d;
    @(negedge ref_clk);
    fldAccess = 1'b0;
    fldWdata = ~d;
  endtask
endmodule

// ---- test_dcm_decimator_ctrl.sv ----
`timescale 1ns/100ps
// Self-checking bench: field coherency, modes and start control
module test_dcm_decimator_ctrl;
  import dcm_pkg::*;
  logic ref_clk, rst, softRst, softStartWrite, extStartSel, extStart, stopCmd, resultValid;
  logic [2:0] cohEnable, interlockFlag;
  logic [1:0] keyGain, keyOffset, keySample, modeSel, fldSel, fldByte;
  logic [7:0] cicRatio;
  logic [9:0] firRatio;
  logic [23:0] resultData, outSample, v;
  logic fldAccess, fldWrite, fldHalf, rdPend;
  logic [15:0] fldWdata, fldRdata, gainCoef;
  logic [3:0] gainWidth;
  logic signed [23:0] offsetCoef;
  logic sampleDropped, busy, chanReset, periodTick, firSample, resultCapture, convDone;
  logic [31:0] expQ[$];
  logic [31:0] r, q;
  int n_mismatch, cmp_count, seed, nCr, nCap, nFir, nTick;

  // 25 MHz clock
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  dcm_decimator_ctrl #(.RATIO_W(8), .FIR_W(10)) dut (
    .ref_clk, .rst, .softRst, .cohEnable, .keyGain, .keyOffset, .keySample,
    .modeSel, .softStartWrite, .extStartSel, .extStart, .stopCmd, .cicRatio,
    .firRatio, .fldAccess, .fldWrite, .fldSel, .fldByte, .fldHalf, .fldWdata,
    .fldRdata, .resultValid, .resultData, .gainCoef, .gainWidth, .offsetCoef,
    .outSample, .interlockFlag, .sampleDropped, .busy, .chanReset, .periodTick,
    .firSample, .resultCapture, .convDone
  );
  dcm_bus_master u_bm (.ref_clk, .fldAccess, .fldWrite, .fldSel, .fldByte, .fldHalf, .fldWdata);

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    cmp_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [1:0] b, input logic h, input logic [15:0] d);
    u_bm.acc(1'b1, FLD_OFFSET, b, h, d);
  endtask

  // Expected read noted with a mask; a byte read returns zero in the upper byte, which the mask leaves unchecked
  task automatic rd(input logic [1:0] b, input logic h, input logic [31:0] e);
    expQ.push_back(e);
    u_bm.acc(1'b0, FLD_SAMPLE, b, h, 16'h0000);
  endtask

  task automatic res(input logic [23:0] d);
    @(negedge ref_clk);
    resultValid = 1'b1;
    resultData = d;
    @(negedge ref_clk);
    resultValid = 1'b0;
    resultData = ~d;
  endtask

  task automatic run(input logic [1:0] m, input int cyc);
    @(negedge ref_clk);
    modeSel = m;
    nCr = 0;
    nCap = 0;
    nFir = 0;
    nTick = 0;
    softStartWrite = 1'b1;
    @(negedge ref_clk);
    softStartWrite = 1'b0;
    repeat (cyc) @(negedge ref_clk);
    stopCmd = 1'b1;
    @(negedge ref_clk);
    stopCmd = 1'b0;
  endtask

  // Read answers land one cycle after the access is taken
  always @(posedge ref_clk)
    rdPend <= fldAccess && !fldWrite;
  always @(negedge ref_clk)
    if (rdPend === 1'b1)
    begin
      // Own holder, so the stimulus value in r is never overwritten
      q = expQ.pop_front();
      chk("read data", {8'h00, q[15:0]}, {8'h00, fldRdata & q[31:16]});
    end

  // Strobe counts at the settled edge; comb strobes would race the rising edge
  always @(negedge ref_clk)
  begin
    nCr += chanReset;
    nCap += resultCapture;
    nFir += firSample;
    nTick += periodTick;
  end

  initial
  begin
    seed = 32'hfd879935;
    rst = 1'b1;
    softRst = 1'b0;
    cohEnable = 3'h7;
    keyGain = 2'h2;
    keyOffset = 2'h2;
    keySample = 2'h2;
    modeSel = MODE_SINGLE;
    softStartWrite = 1'b0;
    extStartSel = 1'b0;
    extStart = 1'b0;
    stopCmd = 1'b0;
    cicRatio = 8'h02;
    firRatio = 10'h003;
    resultValid = 1'b0;
    resultData = 24'h000000;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    chk("flags after reset", 24'h7, interlockFlag);
    // Offset written bytewise; datapath keeps the old value until the key lands
    r = $random(seed);
    v = {1'b1, r[22:0]};
    wr(2'h0, 1'b0, {8'h00, v[7:0]});
    chk("flags non-key write", 24'h5, interlockFlag);
    wr(2'h1, 1'b0, {8'h00, v[15:8]});
    run(MODE_SINGLE, 14);
    chk("shadow incoherent", 24'h0, offsetCoef);
    wr(2'h2, 1'b0, {8'h00, v[23:16]});
    chk("flags key write", 24'h7, interlockFlag);
    run(MODE_SINGLE, 14);
    chk("offset after key", v, offsetCoef);
    r = $random(seed);
    v[15:0] = r[15:0];
    wr(2'h0, 1'b1, v[15:0]);
    chk("flags low half", 24'h5, interlockFlag);
    v[23:8] = r[31:16];
    wr(2'h1, 1'b1, v[23:8]);
    chk("flags key half", 24'h7, interlockFlag);
    // Gain with its width code; only the low nibble of byte 2 is kept
    u_bm.acc(1'b1, FLD_GAIN, 2'h0, 1'b1, r[15:0]);
    chk("flags gain low", 24'h6, interlockFlag);
    u_bm.acc(1'b1, FLD_GAIN, 2'h2, 1'b0, {8'h00, r[23:16]});
    chk("flags gain key", 24'h7, interlockFlag);
    chk("gain before need", 24'h0, gainCoef);
    run(MODE_SINGLE, 14);
    chk("offset from halves", v, offsetCoef);
    chk("gain coef", r[15:0], gainCoef);
    chk("gain width", r[19:16], gainWidth);
    cohEnable = 3'h5;
    wr(2'h0, 1'b0, 16'h00a5);
    @(negedge ref_clk);
    chk("flags untracked", 24'h7, interlockFlag);
    chk("shadow follows", {v[23:8], 8'ha5}, offsetCoef);
    cohEnable = 3'h7;
    // Output sample: non-key read freezes it, key read releases it
    r = $random(seed);
    res(r[23:0]);
    chk("sample stored", r[23:0], outSample);
    rd(2'h0, 1'b1, {16'hffff, r[15:0]});
    chk("flags low read", 24'h3, interlockFlag);
    v = r[23:0];
    r = $random(seed);
    res(r[23:0]);
    chk("sample kept", v, outSample);
    chk("drop flagged", 24'h1, sampleDropped);
    rd(2'h1, 1'b1, {16'hffff, v[23:8]});
    chk("flags key read", 24'h7, interlockFlag);
    res(r[23:0]);
    chk("next sample", r[23:0], outSample);
    rd(2'h0, 1'b0, {16'h00ff, 8'h00, r[7:0]});
    rd(2'h2, 1'b0, {16'h00ff, 8'h00, r[23:16]});
    rd(2'h0, 1'b0, {16'h00ff, 8'h00, r[7:0]});
    softRst = 1'b1;
    @(negedge ref_clk);
    softRst = 1'b0;
    chk("flags soft reset", 24'h7, interlockFlag);
    // Every mode, stopped after a fixed span
    for (int m = 0; m < 4; m++)
    begin
      run(2'(m), 60);
      case (m)
        0: chk("single", 24'h1, nCap == 1 && nCr == 1 && nTick == 4);
        1: chk("fast", 24'h1, nCr > 1 && nCap > 1);
        2: chk("continuous", 24'h1, nCr == 1 && nCap > 20);
        default: chk("fir", 24'h1, nCr > 1 && nCap > 1 && nFir >= 4 * nCap);
      endcase
      chk("idle after stop", 24'h0, busy);
    end
    extStartSel = 1'b1;
    run(MODE_SINGLE, 6);
    chk("soft start ignored", 24'h0, nCr);
    extStart = 1'b1;
    repeat (20) @(negedge ref_clk);
    extStart = 1'b0;
    chk("ext start", 24'h1, nCap);
    final_report();
  end

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial
  begin
    #400000;
    n_mismatch++;
    final_report();
  end
endmodule
